// *** rtl/emp_pkg.sv ***
// package for the energy measurement post-processing stage: types and constants.
// assumes one 200 MHz clock and raw per-phase figures already in milli-units.
// How it works
// - average current is the three phase currents summed and divided by three
// - average line-to-line voltage is the three pair voltages divided by three
// - average phase-to-neutral voltage is the three voltages divided by three
// - maximum demand is highest of three phase and neutral demands since clear
// - minimum demand is lowest of the three phase demands only since clear
// - highest and lowest line-to-line voltage held since the last clear
// - highest and lowest phase-to-neutral voltage held since the last clear
// - stored values truncated to rating resolution; power factor and frequency to 0.1
// - current resolution 0.01 A to 10 A by rated primary current band
// - voltage resolution 0.1 V, or by transformer primary band up to 10 V
// - power resolution from 0.001 kW to 10 kW by full-load band
// - full load kW is three times primary volts times primary amps over 1000
// - energy multiplier -5 below 12 kW, rising one per band to -1
// - phase current under 0.4 percent of rating reads zero
// - phase voltage under 55 V reads zero; no first-phase voltage stops measuring
// - line voltage under 95 V reads zero
// - active power zero when all phase currents are zero; with all voltages zero results hold
// - power factor 100 percent when all phase currents are zero; with all voltages zero it holds
// - frequency holds its last value under first-phase voltage cut-off, clamped up to 44.5 Hz otherwise
// - demands are moving averages and may stay nonzero with zero input
// - every result is refreshed once per 500 ms measuring cycle
package emp_pkg;
	// measuring cycle
	localparam int unsigned MEAS_TIME_MS   = 500;
	localparam int unsigned CLK_FREQ_MHZ   = 200;
	localparam int unsigned MEAS_CYCLES    = MEAS_TIME_MS * 1000 * CLK_FREQ_MHZ;
	// cut-offs in milli-units
	localparam logic [31:0] CUR_CUT_PERMILLE = 32'h0000_0004;   // 0.4 percent
	localparam logic [31:0] VLN_CUT_MV       = 32'h0000_D6D8;   // 55 V
	localparam logic [31:0] VLL_CUT_MV       = 32'h0001_7318;   // 95 V
	localparam logic [31:0] FREQ_MIN_MHZ     = 32'h0000_ADD4;   // 44.5 Hz
	localparam logic [31:0] PF_UNITY         = 32'h0001_86A0;   // 100 percent
	localparam logic [31:0] STEP_TENTH       = 32'h0000_0064;   // 0.1 in milli-units
	localparam logic [31:0] ENERGY_WRAP      = 32'h3B9A_CA00;   // 10^9 counts
	// rating band edges
	localparam logic [15:0] CT_B1 = 16'h001E;                   // 30 A
	localparam logic [15:0] CT_B2 = 16'h012C;                   // 300 A
	localparam logic [15:0] CT_B3 = 16'h0BB8;                   // 3000 A
	localparam logic [15:0] VT_B1 = 16'h0149;                   // 329 V
	localparam logic [15:0] VT_B2 = 16'h08FB;                   // 2299 V
	// full-load bands in decivolt*ampere (kW * 10000)
	localparam logic [39:0] FL_B1 = 40'h00_0001_D4C0;           // 12 kW
	localparam logic [39:0] FL_B2 = 40'h00_0012_4F80;           // 120 kW
	localparam logic [39:0] FL_B3 = 40'h00_00B7_1B00;           // 1200 kW
	localparam logic [39:0] FL_B4 = 40'h00_0727_0E00;           // 12000 kW
	localparam logic [39:0] FL_DIV = 40'h00_0000_2710;          // 10000
	localparam logic [19:0] DV_PER_V = 20'h0000A;
	localparam logic [39:0] FL_PHASES = 40'h00_0000_0003;
	localparam logic [31:0] NO_MIN = 32'hFFFF_FFFF;

	typedef struct packed {
		logic [15:0] ct_a;      // rated primary current, A
		logic        vt_use;    // voltage transformer fitted
		logic [15:0] vt_v;      // transformer primary, V
		logic [15:0] vln_dv;    // direct input L-N rating, 0.1 V
	} emp_cfg_t;

	typedef struct packed {
		logic [3:0][31:0] cur;      // mA, index 3 neutral
		logic [3:0][31:0] cur_dem;  // mA, index 3 neutral
		logic [2:0][31:0] v_ll;     // mV
		logic [2:0][31:0] v_ln;     // mV
		logic [31:0]      p;        // W, signed
		logic [31:0]      q;        // var, signed
		logic [31:0]      s;        // VA
		logic [31:0]      p_dem;    // W, signed
		logic [31:0]      pf;       // milli-percent, signed
		logic [31:0]      freq;     // mHz
		logic [4:0][31:0] energy;   // 1e-5 kWh units
	} emp_raw_t;

	typedef struct packed {
		logic [3:0][31:0] cur;
		logic [31:0]      cur_avg;
		logic [3:0][31:0] cur_dem;
		logic [31:0]      dem_max;
		logic [31:0]      dem_min;
		logic [2:0][31:0] v_ll;
		logic [31:0]      v_ll_avg;
		logic [31:0]      v_ll_max;
		logic [31:0]      v_ll_min;
		logic [2:0][31:0] v_ln;
		logic [31:0]      v_ln_avg;
		logic [31:0]      v_ln_max;
		logic [31:0]      v_ln_min;
		logic [31:0]      p;
		logic [31:0]      q;
		logic [31:0]      s;
		logic [31:0]      p_dem;
		logic [31:0]      pf;
		logic [31:0]      freq;
		logic [4:0][31:0] energy;
		logic [2:0]       band;     // energy multiplier is band-5
	} emp_res_t;
endpackage : emp_pkg

// *** rtl/emp_postproc.sv ***
// top of the energy measurement post-processing stage.
// assumes raw figures on RAW are steady and current whenever a measuring cycle ends.
`timescale 1ns/1ps
module emp_postproc #(
	parameter int unsigned MEAS_CYCLES = emp_pkg::MEAS_CYCLES
) (
	input  wire logic             CLOCK,
	input  wire logic             RST_B,
	input  wire emp_pkg::emp_raw_t RAW,
	input  wire emp_pkg::emp_cfg_t CFG,
	input  wire logic             CFG_APPLY,
	input  wire logic             MM_CLEAR,
	output emp_pkg::emp_res_t     RESULT,
	output logic                  RESULT_UPDATE,
	output logic                  MODULE_READY_FLAG,
	output logic                  OPERATING_CONDITION_DONE_FLAG
);
	// ****************************************
	// helpers
	// ****************************************
	// truncate toward zero onto a step grid
	function automatic logic [31:0] quant(input logic [31:0] v, input logic [31:0] step);
		logic signed [31:0] sv;
		logic signed [31:0] ss;
		sv = $signed(v);
		ss = $signed(step);
		return $unsigned(sv - (sv % ss));
	endfunction : quant

	function automatic logic [31:0] umax(input logic [31:0] a, input logic [31:0] b);
		return (a > b) ? a : b;
	endfunction : umax

	function automatic logic [31:0] umin(input logic [31:0] a, input logic [31:0] b);
		return (a < b) ? a : b;
	endfunction : umin

	function automatic logic [31:0] avg3(input logic [31:0] a, input logic [31:0] b,
		input logic [31:0] c);
		logic [33:0] sum;
		sum = {2'b00, a} + {2'b00, b} + {2'b00, c};
		return 32'((sum / 34'h3));
	endfunction : avg3

	function automatic logic [31:0] pow10(input logic [2:0] n);
		unique case (n)
			3'h0: return 32'h0000_0001;
			3'h1: return 32'h0000_000A;
			3'h2: return 32'h0000_0064;
			3'h3: return 32'h0000_03E8;
			default: return 32'h0000_2710;
		endcase
	endfunction : pow10

	// ****************************************
	// state
	// ****************************************
	logic [31:0]       tick_cnt_ff;
	logic              tick;
	logic              ready_ff;
	logic              done_ff;
	logic              pending_ff;
	emp_pkg::emp_cfg_t cfg_ff;
	emp_pkg::emp_res_t res_ff;
	emp_pkg::emp_res_t nxt_res;
	logic              upd_ff;
	logic              update;
	logic [31:0]       dem_max_ff;
	logic [31:0]       dem_min_ff;
	logic [31:0]       vll_max_ff;
	logic [31:0]       vll_min_ff;
	logic [31:0]       vln_max_ff;
	logic [31:0]       vln_min_ff;
	logic [31:0]       nxt_dem_max;
	logic [31:0]       nxt_dem_min;
	logic [31:0]       nxt_vll_max;
	logic [31:0]       nxt_vll_min;
	logic [31:0]       nxt_vln_max;
	logic [31:0]       nxt_vln_min;

	// ****************************************
	// rating decode
	// ****************************************
	logic [3:0][31:0] cur_cut;
	logic [2:0][31:0] vll_cut;
	logic [2:0][31:0] vln_cut;
	logic [31:0]      cur_thr;
	logic [31:0]      i_step;
	logic [31:0]      v_step;
	logic [19:0]      prim_dv;
	logic [39:0]      full_load;
	logic [2:0]       band;
	logic             no_cur;
	logic             no_volt;
	logic             meas_ok;

	// 0.4 percent of rated amps, expressed in mA
	assign cur_thr = 32'(({16'h0000, cfg_ff.ct_a} * 32'h0000_03E8 *
		emp_pkg::CUR_CUT_PERMILLE) / 32'h0000_03E8);

	// current step by rated primary current band
	always_comb begin
		if (cfg_ff.ct_a <= emp_pkg::CT_B1)
			i_step = 32'h0000_000A;
		else if (cfg_ff.ct_a <= emp_pkg::CT_B2)
			i_step = 32'h0000_0064;
		else if (cfg_ff.ct_a <= emp_pkg::CT_B3)
			i_step = 32'h0000_03E8;
		else
			i_step = 32'h0000_2710;
	end

	// voltage step; the band gap 2300..3299 V is held at 10 V
	always_comb begin
		if (!cfg_ff.vt_use || cfg_ff.vt_v <= emp_pkg::VT_B1)
			v_step = emp_pkg::STEP_TENTH;
		else if (cfg_ff.vt_v <= emp_pkg::VT_B2)
			v_step = 32'h0000_03E8;
		else
			v_step = 32'h0000_2710;
	end

	// full load in decivolt-amperes; kW is this over 10000
	assign prim_dv   = cfg_ff.vt_use ? 20'(cfg_ff.vt_v * emp_pkg::DV_PER_V)
	                                 : {4'h0, cfg_ff.vln_dv};
	assign full_load = emp_pkg::FL_PHASES * {20'h00000, prim_dv} *
	                   {24'h000000, cfg_ff.ct_a};

	// band index shared by power step and energy multiplier
	always_comb begin
		if (full_load < emp_pkg::FL_B1)
			band = 3'h0;
		else if (full_load < emp_pkg::FL_B2)
			band = 3'h1;
		else if (full_load < emp_pkg::FL_B3)
			band = 3'h2;
		else if (full_load < emp_pkg::FL_B4)
			band = 3'h3;
		else
			band = 3'h4;
	end

	// ****************************************
	// input cut-offs
	// ****************************************
	// neutral is never cut: only the phase channels have a rating floor
	for (genvar g = 0; g < 4; g++) begin : g_cur
		assign cur_cut[g] = (g < 3 && RAW.cur[g] < cur_thr) ? '0 : RAW.cur[g];
	end

	for (genvar g = 0; g < 3; g++) begin : g_volt
		assign vln_cut[g] = (RAW.v_ln[g] < emp_pkg::VLN_CUT_MV) ? '0 : RAW.v_ln[g];
		assign vll_cut[g] = (RAW.v_ll[g] < emp_pkg::VLL_CUT_MV) ? '0 : RAW.v_ll[g];
	end

	assign no_cur  = (cur_cut[0] == '0) && (cur_cut[1] == '0) && (cur_cut[2] == '0);
	assign no_volt = (vln_cut[0] == '0) && (vln_cut[1] == '0) && (vln_cut[2] == '0);
	// a dead first phase stops the whole measurement, results hold
	assign meas_ok = (vln_cut[0] != '0);

	// ****************************************
	// measuring cycle timer
	// ****************************************
	// free running so the cycle rate never depends on configuration traffic
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B)
			tick_cnt_ff <= '0;
		else if (tick)
			tick_cnt_ff <= '0;
		else
			tick_cnt_ff <= tick_cnt_ff + 32'h0000_0001;
	end

	assign tick   = (tick_cnt_ff == 32'(MEAS_CYCLES - 1));
	assign update = tick && ready_ff && meas_ok;

	// ****************************************
	// flags and configuration
	// ****************************************
	// ready rises on the first edge after reset release
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B)
			ready_ff <= 1'b0;
		else
			ready_ff <= 1'b1;
	end

	// new ratings are latched at once; results built on them mark done
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B)
			cfg_ff <= '0;
		else if (CFG_APPLY)
			cfg_ff <= CFG;
	end

	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			pending_ff <= 1'b0;
			done_ff    <= 1'b0;
		end else if (CFG_APPLY) begin
			pending_ff <= 1'b1;
			done_ff    <= 1'b0;
		end else if (update && pending_ff) begin
			pending_ff <= 1'b0;
			done_ff    <= 1'b1;
		end
	end

	// ****************************************
	// result calculation
	// ****************************************
	always_comb begin
		nxt_res = res_ff;
		for (int k = 0; k < 4; k++) begin
			nxt_res.cur[k]     = quant(cur_cut[k], i_step);
			// demand is already a moving average upstream, no cut here
			nxt_res.cur_dem[k] = quant(RAW.cur_dem[k], i_step);
		end
		nxt_res.cur_avg = quant(avg3(cur_cut[0], cur_cut[1], cur_cut[2]), i_step);
		for (int k = 0; k < 3; k++) begin
			nxt_res.v_ll[k] = quant(vll_cut[k], v_step);
			nxt_res.v_ln[k] = quant(vln_cut[k], v_step);
		end
		nxt_res.v_ll_avg = quant(avg3(vll_cut[0], vll_cut[1], vll_cut[2]), v_step);
		nxt_res.v_ln_avg = quant(avg3(vln_cut[0], vln_cut[1], vln_cut[2]), v_step);
		nxt_res.p     = (no_cur || no_volt) ? '0 : quant(RAW.p, pow10(band));
		nxt_res.q     = quant(RAW.q, pow10(band));
		nxt_res.s     = quant(RAW.s, pow10(band));
		nxt_res.p_dem = quant(RAW.p_dem, pow10(band));
		nxt_res.pf    = (no_cur || no_volt) ? emp_pkg::PF_UNITY
		                                    : quant(RAW.pf, emp_pkg::STEP_TENTH);
		if (vln_cut[0] == '0)
			nxt_res.freq = '0;
		else if (RAW.freq < emp_pkg::FREQ_MIN_MHZ)
			nxt_res.freq = emp_pkg::FREQ_MIN_MHZ;
		else
			nxt_res.freq = quant(RAW.freq, emp_pkg::STEP_TENTH);
		// coarser band drops digits and keeps the counter inside its range
		for (int k = 0; k < 5; k++)
			nxt_res.energy[k] = (RAW.energy[k] / pow10(band)) % emp_pkg::ENERGY_WRAP;
		nxt_res.band     = band;
		nxt_res.dem_max  = nxt_dem_max;
		nxt_res.dem_min  = nxt_dem_min;
		nxt_res.v_ll_max = nxt_vll_max;
		nxt_res.v_ll_min = nxt_vll_min;
		nxt_res.v_ln_max = nxt_vln_max;
		nxt_res.v_ln_min = nxt_vln_min;
	end

	// ****************************************
	// max and min hold
	// ****************************************
	// a clear in the same cycle as an update restarts from this cycle's values
	always_comb begin
		nxt_dem_max = MM_CLEAR ? '0 : dem_max_ff;
		nxt_dem_min = MM_CLEAR ? emp_pkg::NO_MIN : dem_min_ff;
		nxt_vll_max = MM_CLEAR ? '0 : vll_max_ff;
		nxt_vll_min = MM_CLEAR ? emp_pkg::NO_MIN : vll_min_ff;
		nxt_vln_max = MM_CLEAR ? '0 : vln_max_ff;
		nxt_vln_min = MM_CLEAR ? emp_pkg::NO_MIN : vln_min_ff;
		if (update) begin
			for (int k = 0; k < 4; k++)
				nxt_dem_max = umax(nxt_dem_max, nxt_res.cur_dem[k]);
			for (int k = 0; k < 3; k++) begin
				nxt_dem_min = umin(nxt_dem_min, nxt_res.cur_dem[k]);
				nxt_vll_max = umax(nxt_vll_max, nxt_res.v_ll[k]);
				nxt_vll_min = umin(nxt_vll_min, nxt_res.v_ll[k]);
				nxt_vln_max = umax(nxt_vln_max, nxt_res.v_ln[k]);
				nxt_vln_min = umin(nxt_vln_min, nxt_res.v_ln[k]);
			end
		end
	end

	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			dem_max_ff <= '0;
			dem_min_ff <= emp_pkg::NO_MIN;
			vll_max_ff <= '0;
			vll_min_ff <= emp_pkg::NO_MIN;
			vln_max_ff <= '0;
			vln_min_ff <= emp_pkg::NO_MIN;
		end else begin
			dem_max_ff <= nxt_dem_max;
			dem_min_ff <= nxt_dem_min;
			vll_max_ff <= nxt_vll_max;
			vll_min_ff <= nxt_vll_min;
			vln_max_ff <= nxt_vln_max;
			vln_min_ff <= nxt_vln_min;
		end
	end

	// ****************************************
	// result buffer
	// ****************************************
	// results only move on a measuring cycle; a clear alone shows at the next one
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B)
			res_ff <= '0;
		else if (update)
			res_ff <= nxt_res;
	end

	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B)
			upd_ff <= 1'b0;
		else
			upd_ff <= update;
	end

	assign RESULT                        = res_ff;
	assign RESULT_UPDATE                 = upd_ff;
	assign MODULE_READY_FLAG             = ready_ff;
	assign OPERATING_CONDITION_DONE_FLAG = done_ff;
endmodule : emp_postproc

// *** testbench/emp_postproc_properties.sv ***
// checker for emp_postproc: timing and value relations seen at its ports.
// assumes a bind to emp_postproc, one clock and an active-low async reset.
`timescale 1ns/1ps
module emp_postproc_checker #(
	parameter int unsigned MEAS_CYCLES = 20
) (
	input wire logic              CLOCK,
	input wire logic              RST_B,
	input wire emp_pkg::emp_raw_t RAW,
	input wire emp_pkg::emp_cfg_t CFG,
	input wire logic              CFG_APPLY,
	input wire logic              MM_CLEAR,
	input wire emp_pkg::emp_res_t RESULT,
	input wire logic              RESULT_UPDATE,
	input wire logic              MODULE_READY_FLAG,
	input wire logic              OPERATING_CONDITION_DONE_FLAG
);
	// ********
	// helpers
	// ********
	// true when v is at or above each of three words
	function automatic logic above(input logic [31:0] v, a, b, c);
		return v >= a && v >= b && v >= c;
	endfunction : above
	// true when v is at or below each of three words
	function automatic logic below(input logic [31:0] v, a, b, c);
		return v <= a && v <= b && v <= c;
	endfunction : below
	// cycles since the last update; a refused cycle skips an update but never shifts the grid
	int unsigned gap_cnt_ff;
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B)
			gap_cnt_ff <= 32'h0;
		else if (RESULT_UPDATE)
			gap_cnt_ff <= 32'h1;
		else
			gap_cnt_ff <= gap_cnt_ff + 32'h1;
	end
	// ********
	// properties
	// ********
	// reset gates every check, so a mid-run reset cannot trip the past values
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (!RST_B);
	upd_gap_a: assert property (RESULT_UPDATE |=> !RESULT_UPDATE [*8])
		else $error("result update repeated too soon");
	ready_up_a: assert property (!MODULE_READY_FLAG |=> MODULE_READY_FLAG)
		else $error("ready flag not raised after reset");
	done_at_upd_a: assert property (
		$rose(OPERATING_CONDITION_DONE_FLAG) |-> RESULT_UPDATE)
		else $error("done flag rose without an update");
	upd_needs_v1_a: assert property (RESULT_UPDATE |-> MODULE_READY_FLAG &&
		$past(RAW.v_ln[0]) >= emp_pkg::VLN_CUT_MV)
		else $error("update without ready or first phase voltage");
	dem_max_a: assert property (RESULT_UPDATE |->
		above(RESULT.dem_max, RESULT.cur_dem[0], RESULT.cur_dem[1], RESULT.cur_dem[3]) &&
		RESULT.dem_max >= RESULT.cur_dem[2])
		else $error("demand maximum below a demand");
	dem_min_a: assert property (RESULT_UPDATE |->
		below(RESULT.dem_min, RESULT.cur_dem[0], RESULT.cur_dem[1], RESULT.cur_dem[2]))
		else $error("demand minimum above a phase demand");
	vll_range_a: assert property (RESULT_UPDATE |->
		above(RESULT.v_ll_max, RESULT.v_ll[0], RESULT.v_ll[1], RESULT.v_ll[2]) &&
		below(RESULT.v_ll_min, RESULT.v_ll[0], RESULT.v_ll[1], RESULT.v_ll[2]))
		else $error("line voltage hold out of range");
	vln_range_a: assert property (RESULT_UPDATE |->
		above(RESULT.v_ln_max, RESULT.v_ln[0], RESULT.v_ln[1], RESULT.v_ln[2]) &&
		below(RESULT.v_ln_min, RESULT.v_ln[0], RESULT.v_ln[1], RESULT.v_ln[2]))
		else $error("phase voltage hold out of range");
	pf_unity_a: assert property (RESULT_UPDATE && RESULT.cur[2:0] == '0 |->
		RESULT.pf == emp_pkg::PF_UNITY && RESULT.p == '0)
		else $error("no current but power or power factor not idle");
	freq_floor_a: assert property (RESULT_UPDATE && RESULT.v_ln[0] != '0 |->
		RESULT.freq >= emp_pkg::FREQ_MIN_MHZ && RESULT.freq % 32'h0000_0064 == '0)
		else $error("frequency below floor or not in tenths");
	upd_spacing_a: assert property (RESULT_UPDATE |->
		gap_cnt_ff % MEAS_CYCLES == 32'h0)
		else $error("result update off the measuring cycle grid");
endmodule : emp_postproc_checker

bind emp_postproc emp_postproc_checker #(.MEAS_CYCLES(MEAS_CYCLES)) emp_postproc_checker_i (
	.CLOCK(CLOCK), .RST_B(RST_B), .RAW(RAW), .CFG(CFG), .CFG_APPLY(CFG_APPLY),
	.MM_CLEAR(MM_CLEAR), .RESULT(RESULT), .RESULT_UPDATE(RESULT_UPDATE),
	.MODULE_READY_FLAG(MODULE_READY_FLAG),
	.OPERATING_CONDITION_DONE_FLAG(OPERATING_CONDITION_DONE_FLAG));

// *** testbench/emp_reader_model.sv ***
// reader on the sequencer side: keeps a copy of each result it may use.
// assumes the update pulse and both flags of emp_postproc on one clock.
`timescale 1ns/1ps
module emp_reader_model (
	input  wire logic              clock,
	input  wire logic              rst_b,
	input  wire emp_pkg::emp_res_t result,
	input  wire logic              result_update,
	input  wire logic              ready_flag,
	input  wire logic              done_flag,
	output emp_pkg::emp_res_t      snap,
	output int                     snap_cnt
);
	// a copy is taken only with ready and done both up; earlier data is not valid
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			snap     <= '0;
			snap_cnt <= 0;
		end else if (result_update && ready_flag && done_flag) begin
			snap     <= result;
			snap_cnt <= snap_cnt + 1;
		end
	end
endmodule : emp_reader_model

// *** testbench/test_energy_measurement_postproc.sv ***
// self-checking bench for emp_postproc with a reader model on its result side.
// assumes a short measuring cycle so that each update comes within a few dozen clocks.
`timescale 1ns/1ps
module test_energy_measurement_postproc;
	localparam int unsigned MC = 20;
	logic              CLOCK;
	logic              RST_B;
	emp_pkg::emp_raw_t RAW;
	emp_pkg::emp_cfg_t CFG;
	logic              CFG_APPLY;
	logic              MM_CLEAR;
	emp_pkg::emp_res_t RESULT;
	logic              RESULT_UPDATE;
	logic              MODULE_READY_FLAG;
	logic              OPERATING_CONDITION_DONE_FLAG;
	emp_pkg::emp_res_t snap;
	int                snap_cnt;
	emp_pkg::emp_raw_t r;
	int                err_count;
	int                checks_done;
	// ratings: one per power band, with the current and voltage steps they imply
	logic [15:0] ct_t[5] = '{16'h0005, 16'h001E, 16'h012C, 16'h0190, 16'h1770};
	logic        vt_t[5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
	logic [15:0] vv_t[5] = '{16'h0000, 16'h0000, 16'h0149, 16'h08FB, 16'h19C8};
	logic [31:0] is_t[5] = '{32'h0A, 32'h0A, 32'h64, 32'h3E8, 32'h2710};
	logic [31:0] vs_t[5] = '{32'h64, 32'h64, 32'h64, 32'h3E8, 32'h2710};

	emp_postproc #(.MEAS_CYCLES(MC)) emp_postproc_i (
		.CLOCK(CLOCK), .RST_B(RST_B), .RAW(RAW), .CFG(CFG), .CFG_APPLY(CFG_APPLY),
		.MM_CLEAR(MM_CLEAR), .RESULT(RESULT), .RESULT_UPDATE(RESULT_UPDATE),
		.MODULE_READY_FLAG(MODULE_READY_FLAG),
		.OPERATING_CONDITION_DONE_FLAG(OPERATING_CONDITION_DONE_FLAG));
	emp_reader_model emp_reader_model_i (
		.clock(CLOCK), .rst_b(RST_B), .result(RESULT), .result_update(RESULT_UPDATE),
		.ready_flag(MODULE_READY_FLAG), .done_flag(OPERATING_CONDITION_DONE_FLAG),
		.snap(snap), .snap_cnt(snap_cnt));

	// ********
	// shared tasks
	// ********
	// truncation toward zero to a step
	function automatic logic [31:0] q(input logic [31:0] v, input logic [31:0] s);
		return v - v % s;
	endfunction : q
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : chk
	// new raw figures; waits so an update already sampled with old ones is past
	task automatic put();
		@(posedge CLOCK);
		RAW <= r;
		@(posedge CLOCK);
		@(negedge CLOCK);
	endtask : put
	task automatic apply(input int i);
		@(posedge CLOCK);
		RAW <= r;
		CFG <= '{ct_a: ct_t[i], vt_use: vt_t[i], vt_v: vv_t[i], vln_dv: 16'h08FC};
		CFG_APPLY <= 1'b1;
		@(posedge CLOCK);
		CFG_APPLY <= 1'b0;
		@(negedge CLOCK);
	endtask : apply
	// ends off the edge so a copy taken at the clear edge is not mistaken for a fresh one
	task automatic clear();
		@(posedge CLOCK);
		MM_CLEAR <= 1'b1;
		@(posedge CLOCK);
		MM_CLEAR <= 1'b0;
		@(negedge CLOCK);
	endtask : clear
	// bounded wait for the reader to take a fresh copy
	task automatic wait_upd();
		int n;
		n = snap_cnt;
		for (int i = 0; i < 3 * MC && snap_cnt == n; i++) @(negedge CLOCK);
		chk("update taken", 32'h1, 32'(snap_cnt != n));
	endtask : wait_upd
	task automatic base();
		r = '0;
		r.cur = {32'h0000_03E8, 32'h0005_464E, 32'h0003_9447, 32'h0001_E240};
		r.cur_dem = {4{32'h0000_0BB8}};
		r.v_ll = {3{32'h0006_1F52}};
		r.v_ln = {32'h0003_A981, 32'h0003_826F, 32'h0003_8742};
		r.p = 32'h0012_D687;
		r.pf = 32'h0001_74C8;
		r.q = 32'h0009_8765;
		r.s = 32'h0015_B38F;
		r.p_dem = 32'h0011_D7A3;
		r.freq = 32'h0000_C381;
		r.energy[0] = 32'h075B_CD15;
	endtask : base

	// ********
	// scenarios
	// ********
	task automatic t_reset();
		repeat (2) @(negedge CLOCK);
		chk("ready", 32'h1, 32'(MODULE_READY_FLAG));
		chk("done", 32'h0, 32'(OPERATING_CONDITION_DONE_FLAG));
	endtask : t_reset
	// every rating band: steps, averages, band and energy scaling
	task automatic t_bands();
		logic [31:0] pw;
		for (int i = 0; i < 5; i++) begin
			apply(i);
			wait_upd();
			pw = 32'h1;
			repeat (i) pw = pw * 32'hA;
			chk("cur0", q(r.cur[0], is_t[i]), snap.cur[0]);
			chk("cur avg", q((r.cur[0] + r.cur[1] + r.cur[2]) / 3, is_t[i]), snap.cur_avg);
			chk("vln0", q(r.v_ln[0], vs_t[i]), snap.v_ln[0]);
			chk("vln avg", q((r.v_ln[0] + r.v_ln[1] + r.v_ln[2]) / 3, vs_t[i]), snap.v_ln_avg);
			chk("band", 32'(i), {29'h0, snap.band});
			chk("power", q(r.p, pw), snap.p);
			chk("reactive", q(r.q, pw), snap.q);
			chk("apparent", q(r.s, pw), snap.s);
			chk("power demand", q(r.p_dem, pw), snap.p_dem);
			chk("energy", r.energy[0] / pw, snap.energy[0]);
			chk("pf", q(r.pf, 32'h64), snap.pf);
			chk("freq", q(r.freq, 32'h64), snap.freq);
			chk("done", 32'h1, 32'(OPERATING_CONDITION_DONE_FLAG));
		end
	endtask : t_bands
	// inputs just under each cut-off, low frequency, demand left over
	task automatic t_cut();
		base();
		r.cur[2:0] = {3{32'h0000_0013}};
		r.v_ln[1] = 32'h0000_D6D7;
		r.v_ll[0] = 32'h0001_7317;
		r.freq = 32'h0000_9C40;
		apply(0);
		wait_upd();
		chk("cur0 cut", 32'h0, snap.cur[0]);
		chk("power idle", 32'h0, snap.p);
		chk("pf idle", emp_pkg::PF_UNITY, snap.pf);
		chk("vln1 cut", 32'h0, snap.v_ln[1]);
		chk("vll0 cut", 32'h0, snap.v_ll[0]);
		chk("vll avg", q((r.v_ll[1] + r.v_ll[2]) / 3, 32'h64), snap.v_ll_avg);
		chk("freq floor", emp_pkg::FREQ_MIN_MHZ, snap.freq);
		chk("demand kept", 32'h0000_0BB8, snap.cur_dem[0]);
	endtask : t_cut
	// holds across updates, neutral only in the maximum, then a fresh clear
	task automatic t_minmax();
		base();
		r.cur_dem = {32'h0000_2328, 32'h0000_1B58, 32'h0000_1770, 32'h0000_1388};
		r.v_ll = {32'h0005_F370, 32'h0006_4190, 32'h0006_1A80};
		put();
		clear();
		wait_upd();
		chk("vll max", 32'h0006_4190, snap.v_ll_max);
		chk("vll min", 32'h0005_F370, snap.v_ll_min);
		chk("vln max", 32'h0003_A980, snap.v_ln_max);
		chk("vln min", 32'h0003_820C, snap.v_ln_min);
		r.cur_dem = {32'h0000_03E8, {3{32'h0000_1F40}}};
		put();
		wait_upd();
		chk("dem max held", 32'h0000_2328, snap.dem_max);
		chk("dem min held", 32'h0000_1388, snap.dem_min);
		clear();
		wait_upd();
		chk("dem max new", 32'h0000_1F40, snap.dem_max);
		chk("dem min new", 32'h0000_1F40, snap.dem_min);
	endtask : t_minmax
	// no first-phase voltage: nothing is measured
	task automatic t_refuse();
		int n;
		r.v_ln[0] = 32'h0000_C350;
		put();
		n = snap_cnt;
		repeat (2 * MC + 4) @(negedge CLOCK);
		chk("refused count", 32'(n), 32'(snap_cnt));
	endtask : t_refuse

	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : tally_and_finish

	// 200 MHz clock
	initial begin
		CLOCK = 1'b0;
		forever #2.5 CLOCK = ~CLOCK;
	end
	// run takes about 230 clocks; this limit is about seventeen times that
	initial begin
		#20000;
		err_count++;
		tally_and_finish();
	end
	// main sequence
	initial begin
		RST_B = 1'b0;
		RAW = '0;
		CFG = '0;
		CFG_APPLY = 1'b0;
		MM_CLEAR = 1'b0;
		err_count = 0;
		checks_done = 0;
		base();
		repeat (4) @(posedge CLOCK);
		RST_B <= 1'b1;
		t_reset();
		t_bands();
		t_cut();
		t_minmax();
		t_refuse();
		tally_and_finish();
	end
endmodule : test_energy_measurement_postproc
